// ### verilog/icsm_special_modes.sv
`timescale 1ns/1ps
// How it works
// - A filtered reset pulse clears every flag; byte-pending flag alone is set.
// - Reset input and strobe output share a pin, split by a digital filter.
// - Only a pin low of at least 30 clocks passes the filter as reset.
// - The eight-clock own strobe is too short for the filter to accept.
// - Own or general call address then STOP with no data gives an 8-clock low strobe.
// - Long-distance mode is armed by select bit one written with output enable high.
// - Long-distance mode uses four one-way lines: data out, clock in, data in, clock out.
// - Clock control and byte handling are identical in long-distance and two-wire mode.
// - Long-distance mode drives no interrupt; host polls the pending flag.
// - An all-zero own address puts the block into passive monitor mode.
// - Monitor mode counts itself addressed after any address byte or STOP and stays slave receiver.
// - Monitor mode never acknowledges and never requests an interrupt.
// - Monitor mode never stretches the clock for a pending byte.
// - Monitor mode copies every received byte into the read buffer.
// - Monitor pending flag clears after acknowledge, sets on next first bit.
// - Clock rate select is two bits; the bit counter stays internal.
// - Pending flag sets at transfer start, clears after nine clock pulses.
// - Serial traffic and data access work only with output enable high.
module icsm_special_modes #(
  parameter int unsigned MIN_RESET = icsm_pkg::RESET_MIN_CYCLES
) (
  // Clocks and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       link_clk,
  // Shared reset and strobe pin
  input  wire logic       rst_pin_in,
  output logic            rst_pin_out,
  output logic            rst_pin_oe,
  output logic            ctrl_reset,
  // Two-wire bus pins
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Long-distance lines
  input  wire logic       ld_scl_in,
  input  wire logic       ld_sda_in,
  output logic            ld_scl_out,
  output logic            ld_sda_out,
  // Host control levels
  input  wire logic       serial_output_enable,
  input  wire logic       register_select_bit1,
  input  wire logic       irq_enable,
  input  wire logic       ack_enable,
  input  wire logic [1:0] scl_freq_sel,
  input  wire logic [6:0] own_address_register,
  // Host strobes
  input  wire logic       ctrl_write,
  input  wire logic       data_read,
  input  wire logic       data_write,
  // Host status
  output logic [7:0]      rx_data,
  output logic            byte_pending,
  output logic            addressed,
  output logic            long_distance,
  output logic            monitor_mode,
  output logic            irq_n
);
  import icsm_pkg::*;

  // ----------------------------------------------------------------
  // Link domain: line sampling, framing and bit counting
  // ----------------------------------------------------------------
  logic [1:0] ld_sync_l;
  logic [1:0] scl_sync_l;
  logic [1:0] sda_sync_l;
  logic [1:0] rst_sync_l;
  logic [1:0] ack_sync_l;
  logic       scl_prev;
  logic       sda_prev;
  logic [3:0] bit_count;      // Kept internal, no host view
  logic [7:0] shift_reg;
  logic [7:0] byte_word;
  logic       word_is_addr;
  logic       addr_phase;
  logic       ack_phase;
  logic [4:0] evt_tgl;        // Start, stop, byte, first bit, ack done
  logic       scl_now;
  logic       sda_now;
  logic       rise;
  logic       fall;
  logic       link_rst;
  logic       ack_want;       // Chip-domain request, synchronised below

  // Pick the line pair; framing logic is the same in both modes
  always_ff @(posedge link_clk) begin
    ld_sync_l  <= {ld_sync_l[0], long_distance};
    rst_sync_l <= {rst_sync_l[0], ctrl_reset};
    ack_sync_l <= {ack_sync_l[0], ack_want};
    scl_sync_l <= {scl_sync_l[0], ld_sync_l[1] ? ld_scl_in : scl_in};
    sda_sync_l <= {sda_sync_l[0], ld_sync_l[1] ? ld_sda_in : sda_in};
  end

  assign link_rst = rst_sync_l[1];
  assign scl_now  = scl_sync_l[1];
  assign sda_now  = sda_sync_l[1];
  assign rise     = scl_now && !scl_prev;
  assign fall     = !scl_now && scl_prev;

  // Previous line levels for edge finding
  always_ff @(posedge link_clk) begin
    scl_prev <= link_rst ? 1'b1 : scl_now;
    sda_prev <= link_rst ? 1'b1 : sda_now;
  end

  // Framing: START restarts the count, SCL rises shift bits in
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      bit_count    <= 4'h0;
      shift_reg    <= 8'h00;
      byte_word    <= 8'h00;
      word_is_addr <= 1'b0;
      addr_phase   <= 1'b0;
      ack_phase    <= 1'b0;
      evt_tgl      <= 5'h00;
    end else if (scl_now && sda_prev && !sda_now) begin
      bit_count  <= 4'h0;
      addr_phase <= 1'b1;
      ack_phase  <= 1'b0;
      evt_tgl[0] <= !evt_tgl[0];
    end else if (scl_now && !sda_prev && sda_now) begin
      bit_count  <= 4'h0;
      addr_phase <= 1'b0;
      ack_phase  <= 1'b0;
      evt_tgl[1] <= !evt_tgl[1];
    end else if (rise && bit_count < LAST_DATA_BIT) begin
      shift_reg <= {shift_reg[6:0], sda_now};
      bit_count <= bit_count + 4'h1;
      if (bit_count == 4'h0) begin
        evt_tgl[3] <= !evt_tgl[3];
      end
    end else if (fall && bit_count == LAST_DATA_BIT && !ack_phase) begin
      // Word is held steady for nine SCL periods, plenty for the crossing
      byte_word    <= shift_reg;
      word_is_addr <= addr_phase;
      ack_phase    <= 1'b1;
      evt_tgl[2]   <= !evt_tgl[2];
    end else if (fall && ack_phase) begin
      bit_count  <= 4'h0;
      addr_phase <= 1'b0;
      ack_phase  <= 1'b0;
      evt_tgl[4] <= !evt_tgl[4];
    end
  end

  // Acknowledge is driven only from the eighth to the ninth SCL falling edge
  assign sda_oe     = ack_phase && ack_sync_l[1] && !ld_sync_l[1];
  assign sda_out    = 1'b0;
  assign ld_sda_out = !(ack_phase && ack_sync_l[1] && ld_sync_l[1]);

  // ----------------------------------------------------------------
  // Event crossing into the chip clock domain
  // ----------------------------------------------------------------
  logic [4:0] evt_s1;
  logic [4:0] evt_s2;
  logic [4:0] evt_s3;
  logic [4:0] evt;
  logic       ev_start;
  logic       ev_stop;
  logic       ev_byte;
  logic       ev_first;
  logic       ev_ackdone;

  always_ff @(posedge clk) begin
    evt_s1 <= evt_tgl;
    evt_s2 <= evt_s1;
    evt_s3 <= reset_n ? evt_s2 : 5'h00;
  end

  assign evt        = (evt_s2 ^ evt_s3) & {5{reset_n}};
  assign ev_start   = evt[0];
  assign ev_stop    = evt[1];
  assign ev_byte    = evt[2];
  assign ev_first   = evt[3];
  assign ev_ackdone = evt[4];

  // ----------------------------------------------------------------
  // Shared pin: synchroniser, filter and strobe generator
  // ----------------------------------------------------------------
  logic         rst_s1;
  logic         rst_s2;
  logic         filt_reset;
  logic         ctl_rst;
  logic [3:0]   strobe_count;
  logic [3:0]   blank_count;
  logic         strobe_on;
  icsm_strobe_t strobe_state;
  icsm_strobe_t next_strobe_state;
  logic         addr_only;

  always_ff @(posedge clk) begin
    rst_s1 <= rst_pin_in;
    rst_s2 <= rst_s1;
  end

  // Blind while driving and for a short tail to cover sync latency
  always_ff @(posedge clk) begin
    if (!reset_n || strobe_on) begin
      blank_count <= 4'(BLANK_CYCLES);
    end else if (blank_count != 4'h0) begin
      blank_count <= blank_count - 4'h1;
    end
  end

  icsm_reset_filter #(
    .MIN_LOW   (MIN_RESET)
  ) u_filter (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_level (rst_s2),
    .blank     (strobe_on || blank_count != 4'h0),
    .reset_out (filt_reset)
  );

  assign ctl_rst    = !reset_n || filt_reset;
  assign ctrl_reset = ctl_rst;

  // Strobe pulse after a bare address followed by STOP
  always_comb begin
    case (strobe_state)
      ICSM_ST_IDLE:  next_strobe_state = (ev_stop && addr_only) ? ICSM_ST_PULSE : ICSM_ST_IDLE;
      ICSM_ST_PULSE: next_strobe_state = (strobe_count == 4'h1) ? ICSM_ST_IDLE : ICSM_ST_PULSE;
      default:       next_strobe_state = ICSM_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      strobe_state <= ICSM_ST_IDLE;
      strobe_count <= 4'h0;
    end else begin
      strobe_state <= next_strobe_state;
      if (strobe_state == ICSM_ST_IDLE && next_strobe_state == ICSM_ST_PULSE) begin
        strobe_count <= 4'(STROBE_CYCLES);
      end else if (strobe_count != 4'h0) begin
        strobe_count <= strobe_count - 4'h1;
      end
    end
  end

  assign strobe_on   = (strobe_state == ICSM_ST_PULSE);
  assign rst_pin_oe  = strobe_on;
  assign rst_pin_out = 1'b0;

  // ----------------------------------------------------------------
  // Modes and host status
  // ----------------------------------------------------------------
  logic        addr_match;
  logic [15:0] release_count;
  logic        stretch;

  assign monitor_mode = (own_address_register == MONITOR_ADDR);
  assign addr_match   = monitor_mode
                     || byte_word[7:1] == own_address_register
                     || byte_word[7:1] == GENERAL_CALL_ADDR;

  // Long-distance mode, cleared by any data access until rearmed
  always_ff @(posedge clk) begin
    if (ctl_rst || !serial_output_enable || data_read || data_write) begin
      long_distance <= 1'b0;
    end else if (ctrl_write && register_select_bit1) begin
      long_distance <= 1'b1;
    end
  end

  // Addressed flag and bare-address tracking for the strobe
  always_ff @(posedge clk) begin
    if (ctl_rst || !serial_output_enable || ev_stop) begin
      addressed <= monitor_mode && serial_output_enable && !ctl_rst;
    end else if (ev_byte && word_is_addr) begin
      addressed <= addr_match;
    end
  end

  always_ff @(posedge clk) begin
    if (ctl_rst || ev_start || (ev_byte && !word_is_addr) || strobe_on) begin
      addr_only <= 1'b0;
    end else if (ev_byte && word_is_addr) begin
      addr_only <= addr_match && !monitor_mode && serial_output_enable;
    end
  end

  // Acknowledge wanted for this byte; never in monitor mode
  always_ff @(posedge clk) begin
    if (ctl_rst || ev_first || ev_ackdone || monitor_mode) begin
      ack_want <= 1'b0;
    end else if (ev_byte && serial_output_enable) begin
      ack_want <= word_is_addr ? addr_match : (addressed && ack_enable);
    end
  end

  // Byte-pending flag; set events win over the clearing one
  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      byte_pending <= PENDING_RESET;
    end else if (monitor_mode && ev_first) begin
      byte_pending <= 1'b1;
    end else if (!monitor_mode && (data_read || data_write || ev_start)
                 && serial_output_enable) begin
      byte_pending <= 1'b1;
    end else if (ev_ackdone && addressed && serial_output_enable) begin
      byte_pending <= 1'b0;
    end
  end

  // Read buffer is loaded in the acknowledge phase
  always_ff @(posedge clk) begin
    if (ctl_rst) begin
      rx_data <= 8'h00;
    end else if (ev_byte && serial_output_enable && (monitor_mode || addressed)) begin
      rx_data <= byte_word;
    end
  end

  // ----------------------------------------------------------------
  // Clock stretch with rate-dependent release delay
  // ----------------------------------------------------------------
  // Release waits a setup time scaled by the 2-bit rate select
  always_ff @(posedge clk) begin
    if (ctl_rst || !byte_pending) begin
      release_count <= 16'(RELEASE_BASE) << scl_freq_sel;
    end else if (release_count != 16'h0000) begin
      release_count <= release_count - 16'h0001;
    end
  end

  assign stretch = serial_output_enable && addressed && !monitor_mode
                && (!byte_pending || release_count != 16'h0000);
  assign scl_oe     = stretch && !long_distance;
  assign scl_out    = 1'b0;
  assign ld_scl_out = !(stretch && long_distance);

  // Interrupt line quiet in long-distance and monitor modes
  assign irq_n = !(irq_enable && !byte_pending && serial_output_enable
                 && !long_distance && !monitor_mode);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_strobe_start;
    !rst_pin_oe ##1 rst_pin_oe;
  endsequence

  sequence s_low_run;
    !rst_s2 && !strobe_on && blank_count == 4'h0;
  endsequence

  a_strobe_width: assert property (
    s_strobe_start |-> rst_pin_oe [*8] ##1 !rst_pin_oe)
    else $error("strobe pulse is not eight cycles");

  a_strobe_no_reset: assert property (
    $fell(rst_pin_oe) |-> !filt_reset [*8])
    else $error("own strobe reached the reset filter");

  a_filter_accept: assert property (
    (s_low_run [*8] ##1 (!rst_s2 && !strobe_on && blank_count == 4'h0 && !filt_reset))
      |-> ##[1:30] (filt_reset || rst_s2 || blank_count != 4'h0))
    else $error("long reset pulse not taken");

  a_pending_reset: assert property (
    ctl_rst |=> byte_pending && !addressed && !long_distance && rx_data == 8'h00)
    else $error("flags wrong after reset");

  a_ld_irq_quiet: assert property (
    long_distance |-> irq_n)
    else $error("interrupt driven in long distance mode");

  a_monitor_quiet: assert property (
    monitor_mode |-> ##1 (!ack_want && irq_n))
    else $error("monitor mode acknowledged or interrupted");

  a_monitor_stretch: assert property (
    monitor_mode |-> !scl_oe && ld_scl_out)
    else $error("monitor mode stretched the clock");

  a_ld_rearm: assert property (
    (data_read || data_write) |=> !long_distance)
    else $error("long distance kept after data access");

  a_monitor_copy: assert property (
    monitor_mode && ev_byte && serial_output_enable && !ctl_rst
      |=> rx_data == $past(byte_word))
    else $error("monitor byte not copied");

endmodule : icsm_special_modes

// ### verilog/icsm_pkg.sv
package icsm_pkg;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int unsigned RESET_MIN_CYCLES = 30;  // Shortest pin low taken as reset
  localparam int unsigned STROBE_CYCLES    = 8;   // Width of the own strobe pulse
  localparam int unsigned BLANK_CYCLES     = 4;   // Filter blind time after a strobe
  localparam int unsigned RELEASE_BASE     = 16;  // Clock release delay, select 0

  // ----------------------------------------------------------------
  // Field values
  // ----------------------------------------------------------------
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [6:0] MONITOR_ADDR      = 7'h00;
  localparam logic [3:0] LAST_DATA_BIT     = 4'h8;  // Count after eight data bits
  localparam logic       PENDING_RESET     = 1'b1;  // Byte-pending flag after reset

  // ----------------------------------------------------------------
  // Strobe state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ICSM_ST_IDLE  = 2'b01,
    ICSM_ST_PULSE = 2'b10
  } icsm_strobe_t;

endpackage : icsm_pkg

// ### verilog/icsm_reset_filter.sv
`timescale 1ns/1ps
// Counts cycles of a low pin; only a long enough low run counts as reset
module icsm_reset_filter #(
  parameter int unsigned MIN_LOW = 30
) (
  // Clock and system reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Synchronised pin level and blanking
  input  wire logic pin_level,
  input  wire logic blank,
  // Filtered reset
  output logic      reset_out
);
  import icsm_pkg::*;

  logic [7:0] low_count;

  // ----------------------------------------------------------------
  // Low run counter
  // ----------------------------------------------------------------
  // Blanking wipes the count, so the own strobe never builds a run
  always_ff @(posedge clk) begin
    if (!reset_n || blank || pin_level) begin
      low_count <= 8'h00;
    end else if (low_count != 8'(MIN_LOW)) begin
      low_count <= low_count + 8'h01;
    end
  end

  // Reset holds from the counted edge until the pin goes high again
  always_ff @(posedge clk) begin
    if (!reset_n || blank || pin_level) begin
      reset_out <= 1'b0;
    end else if (low_count == 8'(MIN_LOW - 1)) begin
      reset_out <= 1'b1;
    end
  end

endmodule : icsm_reset_filter

// ### tb/icsm_bus_master.sv
`timescale 1ns/1ps
// ----------------------------------------
// Two-wire bus master model
// ----------------------------------------
module icsm_bus_master #(
  parameter int PHASE = 40
) (
  // Clock and resolved lines
  input  wire logic clk,
  input  wire logic scl_line,
  input  wire logic sda_line,
  // Open-drain pulls, 0 drives low
  output logic      m_scl,
  output logic      m_sda
);
  // Both lines released at start; pull-ups hold them high
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  task automatic gap();
    repeat (PHASE) @(posedge clk);
  endtask : gap
  // Release clock and wait out a stretch, bounded so a stuck line cannot hang us
  task automatic scl_high();
    int n;
    n = 0;
    m_scl <= 1'b1;
    @(posedge clk);
    while (scl_line !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    gap();
  endtask : scl_high
  // Data moves only with the clock low, so no false start or stop
  task automatic put_bit(input logic b);
    m_sda <= b;
    gap();
    scl_high();
    m_scl <= 1'b0;
    gap();
  endtask : put_bit
  task automatic start_cond();
    scl_high();
    m_sda <= 1'b0;
    gap();
    m_scl <= 1'b0;
    gap();
  endtask : start_cond
  // One fixed format, MSB first, then the ack slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    m_sda <= 1'b1;
    gap();
    scl_high();
    ack = sda_line;
    m_scl <= 1'b0;
    gap();
  endtask : send_byte
  task automatic stop_cond();
    m_sda <= 1'b0;
    gap();
    scl_high();
    m_sda <= 1'b1;
    gap();
  endtask : stop_cond
endmodule : icsm_bus_master

// ### tb/icsm_special_modes_tb.sv
`timescale 1ns/1ps
module icsm_special_modes_tb;
  import icsm_pkg::*;
  // ----------------------------------------
  // Stimulus, lines and watch state
  // ----------------------------------------
  logic       clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       ext_low = 1'b0;
  logic       serial_output_enable = 1'b1;
  logic       register_select_bit1 = 1'b0;
  logic       irq_en = 1'b0;
  logic       ctrl_write = 1'b0;
  logic       data_read = 1'b0;
  logic       data_write = 1'b0;
  logic       clr = 1'b0;
  logic       ack;
  logic [6:0] own_address_register = 7'h2A;
  logic [7:0] run = 8'h00;
  logic [7:0] len = 8'h00;
  logic [4:0] seen = 5'h00;
  logic [7:0] rx_data;
  logic [7:0] addr_tab [2] = '{8'h54, 8'h00};
  logic       m_scl, m_sda, rst_pin_out, rst_pin_oe, ctrl_reset, scl_out, scl_oe;
  logic       sda_out, sda_oe, ld_sda_out, byte_pending, addressed, long_distance;
  logic       monitor_mode, irq_n, ld_scl_out;
  wire        rst_line = ~(rst_pin_oe & ~rst_pin_out) & ~ext_low;
  wire        scl_line = ~(scl_oe & ~scl_out) & m_scl;
  wire        sda_line = ~(sda_oe & ~sda_out) & m_sda;
  int         err_total = 0;
  int         num_checks = 0;
  // Chip clock 100 MHz; link clock 6 ns with an odd start so phases never align
  always #5 clk = ~clk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  icsm_special_modes u_dut (
    .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .rst_pin_in(rst_line),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .ctrl_reset(ctrl_reset),
    .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .ld_scl_in(scl_line), .ld_sda_in(sda_line),
    .ld_scl_out(ld_scl_out), .ld_sda_out(ld_sda_out),
    .serial_output_enable(serial_output_enable),
    .register_select_bit1(register_select_bit1), .irq_enable(irq_en), .ack_enable(1'b1),
    .scl_freq_sel(2'b01), .own_address_register(own_address_register),
    .ctrl_write(ctrl_write), .data_read(data_read), .data_write(data_write),
    .rx_data(rx_data), .byte_pending(byte_pending), .addressed(addressed),
    .long_distance(long_distance), .monitor_mode(monitor_mode), .irq_n(irq_n));
  icsm_bus_master u_m (.clk(clk), .scl_line(scl_line), .sda_line(sda_line),
    .m_scl(m_scl), .m_sda(m_sda));
  // Strobe width and sticky event flags: reset, clock hold, irq, link ack, ack drive
  always @(posedge clk) begin
    if (clr) begin
      run <= 8'h00;
      len <= 8'h00;
      seen <= 5'h00;
    end else begin
      run <= rst_pin_oe ? run + 8'h01 : 8'h00;
      if (!rst_pin_oe && run != 8'h00) len <= run;
      seen <= seen | {ctrl_reset, scl_oe, ~irq_n, ~ld_sda_out, sda_oe};
    end
  end
  // ----------------------------------------
  // Access tasks and compares
  // ----------------------------------------
  task automatic report(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : report
  task automatic chk_bit(input logic got, input logic exp);
    report({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    report(got, exp);
  endtask : chk_byte
  // One-cycle host pulse, then let the answer land
  task automatic host(input logic cw, input logic dr, input logic dw);
    @(posedge clk);
    ctrl_write <= cw;
    data_read <= dr;
    data_write <= dw;
    @(posedge clk);
    ctrl_write <= 1'b0;
    data_read <= 1'b0;
    data_write <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : host
  task automatic pin_low(input int n);
    @(posedge clk);
    ext_low <= 1'b1;
    repeat (n) @(posedge clk);
    ext_low <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : pin_low
  task automatic clear_watch();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : clear_watch
  task automatic conclude();
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  // Hang guard, well past the expected run of about 7k cycles
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_byte(rx_data, 8'h00);
    chk_byte({byte_pending, addressed, long_distance, irq_n, 4'h0}, 8'h90);
    clear_watch();
    register_select_bit1 <= 1'b1;
    host(1'b1, 1'b0, 1'b0);
    chk_bit(long_distance, 1'b1);
    host(1'b0, 1'b1, 1'b0);
    chk_bit(long_distance, 1'b0);
    host(1'b1, 1'b0, 1'b0);
    host(1'b0, 1'b0, 1'b1);
    chk_bit(long_distance, 1'b0);
    host(1'b1, 1'b0, 1'b0);
    pin_low(20);
    chk_byte({3'h0, seen[4], 3'h0, long_distance}, 8'h01);
    pin_low(40);
    chk_byte({3'h0, seen[4], 2'h0, byte_pending, long_distance}, 8'h12);
    chk_bit(ctrl_reset, 1'b0);
    serial_output_enable <= 1'b0;
    host(1'b1, 1'b0, 1'b0);
    chk_bit(long_distance, 1'b0);
    serial_output_enable <= 1'b1;
    register_select_bit1 <= 1'b0;
    // Own address and general call, each followed straight by a stop
    for (int i = 0; i < 2; i++) begin
      clear_watch();
      u_m.start_cond();
      u_m.send_byte(addr_tab[i], ack);
      chk_bit(ack, 1'b0);
      chk_bit(byte_pending, 1'b0);
      host(1'b0, 1'b1, 1'b0);
      u_m.stop_cond();
      repeat (40) @(posedge clk);
      chk_byte(len, 8'h08);
      chk_byte({3'h0, seen & 5'b11101}, 8'h09);
    end
    // Long-distance traffic: ack leaves on the link line, no irq
    irq_en <= 1'b1;
    register_select_bit1 <= 1'b1;
    clear_watch();
    host(1'b1, 1'b0, 1'b0);
    u_m.start_cond();
    u_m.send_byte(8'h54, ack);
    chk_bit(byte_pending, 1'b0);
    chk_bit(ld_scl_out, 1'b0);
    chk_bit(ack, 1'b1);
    chk_byte({3'h0, seen & 5'b10111}, 8'h02);
    host(1'b0, 1'b1, 1'b0);
    u_m.stop_cond();
    register_select_bit1 <= 1'b0;
    own_address_register <= 7'h00;
    repeat (40) @(posedge clk);
    chk_bit(monitor_mode, 1'b1);
    clear_watch();
    u_m.start_cond();
    u_m.send_byte(8'hA5, ack);
    chk_byte({ack, byte_pending, addressed, 5'h00}, 8'hA0);
    chk_byte(rx_data, 8'hA5);
    fork
      u_m.send_byte(8'h3C, ack);
      begin
        repeat (200) @(posedge clk);
        chk_bit(byte_pending, 1'b1);
      end
    join
    chk_byte(rx_data, 8'h3C);
    chk_bit(ack, 1'b1);
    u_m.stop_cond();
    chk_byte({3'h0, seen}, 8'h00);
    conclude();
  end
endmodule : icsm_special_modes_tb
